// ===== logic/legality_pkg.sv
// legality lookup constants: table window, command fields, counts
// assumes a 16-bit command word with address, t/r, subaddress and count
package legality_pkg;

   // ==========================================================
   // table window in shared ram
   localparam logic [15:0] TABLE_BASE      = 16'h0200;
   localparam logic [15:0] TABLE_LAST      = 16'h02ff;
   localparam int          TABLE_WORDS     = 256;
   localparam int          TABLE_AW        = 8;
   localparam logic [15:0] TX_SA1_LEGAL_LOW_COUNTS  = 16'h02c2;
   localparam logic [15:0] TX_SA1_LEGAL_HIGH_COUNTS = 16'h02c3;
   localparam logic [15:0] TABLE_RESET     = 16'h0000;

   // ==========================================================
   // address weights inside the window
   localparam logic [7:0]  NONBCAST_WEIGHT = 8'h80;
   localparam logic [7:0]  TR_WEIGHT       = 8'h40;

   // ==========================================================
   // command word fields
   localparam int          TR_BIT          = 10;
   localparam int          SA_MSB          = 9;
   localparam int          SA_LSB          = 5;
   localparam int          WC_MSB          = 4;
   localparam logic [4:0]  SA_MODE_ZERO    = 5'h00;
   localparam logic [4:0]  SA_MODE_ONES    = 5'h1f;
   localparam logic [5:0]  WORDS_FOR_ZERO  = 6'h20;
   localparam logic [4:0]  MC_RX_UNDEF_A   = 5'h10;
   localparam logic [4:0]  MC_RX_UNDEF_B   = 5'h12;
   localparam logic [4:0]  MC_RX_UNDEF_C   = 5'h13;
   localparam logic [4:0]  MC_TX_UNDEF_A   = 5'h11;
   localparam logic [4:0]  MC_TX_UNDEF_B   = 5'h14;
   localparam logic [4:0]  MC_TX_UNDEF_C   = 5'h15;

endpackage

// ===== logic/legality_ram_if.sv
// port bundle between the lookup logic and its table memory
// assumes one port, read data registered one cycle after request
`timescale 1ns/1ns
interface legality_ram_if;
   logic [7:0]  addr;
   logic        we;
   logic [15:0] wdata;
   logic [15:0] rdata;

   modport ctrl (output addr, output we, output wdata, input rdata);
   modport mem  (input addr, input we, input wdata, output rdata);
endinterface

// ===== logic/legality_table_ram.sv
// 256 x 16 table memory, registered read data
// assumes single clock; contents are cleared by the controller
`timescale 1ns/1ns
module legality_table_ram (
   input  wire logic     clk_i,
   legality_ram_if.mem   port
);
   logic [15:0] mem [legality_pkg::TABLE_WORDS];
   logic [15:0] rd;

   // ==========================================================
   // write and registered read
   always_ff @(posedge clk_i) begin
      if (port.we) begin
         mem[port.addr] <= port.wdata;
      end
      rd <= mem[port.addr];
   end

   assign port.rdata = rd;
endmodule

// ===== logic/rt_command_legality_check.sv
// legality lookup for a remote terminal: table, clear, command judging
// assumes host and command inputs come from logic on CLK_I
//
// Functional notes
// [RULE1] with an all-zero table every valid command gets clear status, full data
// [RULE2] illegal command: status only, message error set, no data, status updated
// [RULE3] table is 256 words of shared ram at 0x0200 to 0x02ff
// [RULE4] after reset all table words are cleared, then ready rises
// [RULE5] once execution starts each valid command fetches one table bit; here a command arriving in ST_LOOKUP or ST_HOST_RD is dropped
// [RULE6] bit zero means legal: clear status, defined data words, status updated
// [RULE7] index covers t/r, broadcast, subaddress and count or mode code
// [RULE8] broadcast and non-broadcast, transmit and receive use separate entries
// [RULE9] even word: bit zero is 32 words, bit n is n words
// [RULE10] odd word: bit zero is 16 words, bit fifteen is 31 words
// [RULE11] subaddress 0 or 31 index mode codes, even 0-15, odd 16-31
// [RULE12] both mode subaddresses act alike; host programs matching words
// [RULE13] broadcast transmit subaddress commands are invalid, no response
// [RULE14] word address from t/r, subaddress, count msb and broadcast
// [RULE15] transmit subaddress one uses words 0x02c2 and 0x02c3
// [RULE16] host writes ones for every illegal combination to enable checking
// [RULE17] host applies checking to all illegal commands or clears the table
// [RULE18] undefined mode codes are invalid only when the config bit is set
// [RULE19] address = base + ~bcast*128 + tr*64 + sa*2 + count msb
`timescale 1ns/1ns
module rt_command_legality_check (
   input  wire logic        CLK_I,
   input  wire logic        RSTN_I,
   input  wire logic        TERMINAL_EXEC_START_I,
   input  wire logic        UNDEFINED_MODECODE_INVALID_I,
   input  wire logic        CMD_VALID_I,
   input  wire logic [15:0] CMD_WORD_I,
   input  wire logic        CMD_BCAST_I,
   input  wire logic        HOST_REQ_I,
   input  wire logic        HOST_WE_I,
   input  wire logic [15:0] HOST_ADDR_I,
   input  wire logic [15:0] HOST_WDATA_I,
   output logic             READY_O,
   output logic             HOST_ACK_O,
   output logic [15:0]      HOST_RDATA_O,
   output logic             RESP_VALID_O,
   output logic             RESP_NONE_O,
   output logic             RESP_MSG_ERR_O,
   output logic [5:0]       RESP_DATA_WORDS_O,
   output logic             STATUS_UPDATE_O
);

   typedef enum logic [2:0] {
      ST_CLEAR,
      ST_IDLE,
      ST_LOOKUP,
      ST_HOST_RD
   } state_t;

   legality_ram_if ram ();

   legality_table_ram u_ram (
      .clk_i (CLK_I),
      .port  (ram.mem)
   );

   // ==========================================================
   // decode helpers
   function automatic logic is_mode(input logic [4:0] sa);
      is_mode = (sa == legality_pkg::SA_MODE_ZERO) ||
                (sa == legality_pkg::SA_MODE_ONES);
   endfunction

   function automatic logic is_undef_mode(input logic       tr,
                                          input logic [4:0] mc);
      if (!tr) begin
         is_undef_mode = !mc[4] || (mc == legality_pkg::MC_RX_UNDEF_A) ||
                         (mc == legality_pkg::MC_RX_UNDEF_B) ||
                         (mc == legality_pkg::MC_RX_UNDEF_C);
      end else begin
         is_undef_mode = (mc == legality_pkg::MC_TX_UNDEF_A) ||
                         (mc == legality_pkg::MC_TX_UNDEF_B) ||
                         (mc == legality_pkg::MC_TX_UNDEF_C);
      end
   endfunction

   function automatic logic [7:0] table_index(input logic [15:0] cw,
                                              input logic        bc);
      logic [7:0] idx;
      idx = {2'b00, cw[legality_pkg::SA_MSB:legality_pkg::SA_LSB], 1'b0}; // [RULE19]
      idx[0] = cw[legality_pkg::WC_MSB];                                // [RULE14]
      if (!bc) begin
         idx = idx + legality_pkg::NONBCAST_WEIGHT;                       // [RULE8]
      end
      if (cw[legality_pkg::TR_BIT]) begin
         idx = idx + legality_pkg::TR_WEIGHT;                             // [RULE8]
      end
      table_index = idx;                                                  // [RULE7]
   endfunction

   // ==========================================================
   // state and registered outputs
   state_t      state;
   state_t      next_state;
   logic [7:0]  clr_cnt;
   logic [7:0]  next_clr_cnt;
   logic [15:0] cmd;
   logic [15:0] next_cmd;
   logic        bcast;
   logic        next_bcast;
   logic        ready;
   logic        next_ready;
   logic        ack;
   logic        next_ack;
   logic [15:0] hrdata;
   logic [15:0] next_hrdata;
   logic        rvalid;
   logic        next_rvalid;
   logic        rnone;
   logic        next_rnone;
   logic        rerr;
   logic        next_rerr;
   logic [5:0]  rwords;
   logic [5:0]  next_rwords;
   logic        supd;
   logic        next_supd;

   logic        host_in_table;
   logic [4:0]  sa;
   logic [4:0]  wc;
   logic        illegal;
   logic        invalid;
   logic [5:0]  words;

   // ==========================================================
   // next values
   always_comb begin
      next_state  = state;
      next_clr_cnt = clr_cnt;
      next_cmd    = cmd;
      next_bcast  = bcast;
      next_ready  = ready;
      next_ack    = 1'b0;
      next_hrdata = hrdata;
      next_rvalid = 1'b0;
      next_rnone  = rnone;
      next_rerr   = rerr;
      next_rwords = rwords;
      next_supd   = 1'b0;
      ram.addr    = 8'h00;
      ram.we      = 1'b0;
      ram.wdata   = legality_pkg::TABLE_RESET;
      host_in_table = (HOST_ADDR_I >= legality_pkg::TABLE_BASE) &&
                      (HOST_ADDR_I <= legality_pkg::TABLE_LAST);     // [RULE3]
      sa      = cmd[legality_pkg::SA_MSB:legality_pkg::SA_LSB];
      wc      = cmd[legality_pkg::WC_MSB:0];
      illegal = ram.rdata[wc[3:0]];                      // [RULE9] [RULE10] [RULE11]
      invalid = (bcast && cmd[legality_pkg::TR_BIT] && !is_mode(sa)) || // [RULE13]
                (is_mode(sa) && UNDEFINED_MODECODE_INVALID_I &&
                 is_undef_mode(cmd[legality_pkg::TR_BIT], wc));     // [RULE18]
      if (is_mode(sa)) begin
         words = {5'b00000, wc[4]};                                 // [RULE12]
      end else if (wc == 5'h00) begin
         words = legality_pkg::WORDS_FOR_ZERO;
      end else begin
         words = {1'b0, wc};
      end
      unique case (state)
         ST_CLEAR: begin
            ram.addr     = clr_cnt;
            ram.we       = 1'b1;                                    // [RULE4]
            next_clr_cnt = clr_cnt + 8'h01;
            if (clr_cnt == 8'hff) begin
               next_state = ST_IDLE;
               next_ready = 1'b1;                                   // [RULE4]
            end
         end
         ST_IDLE: begin
            if (CMD_VALID_I && TERMINAL_EXEC_START_I) begin          // [RULE5]
               next_cmd   = CMD_WORD_I;
               next_bcast = CMD_BCAST_I;
               ram.addr   = table_index(CMD_WORD_I, CMD_BCAST_I);
               next_state = ST_LOOKUP;
            end else if (HOST_REQ_I) begin
               ram.addr  = HOST_ADDR_I[7:0];
               ram.we    = HOST_WE_I && host_in_table;
               ram.wdata = HOST_WDATA_I;
               if (HOST_WE_I) begin
                  next_ack = 1'b1;
               end else begin
                  next_state = ST_HOST_RD;
               end
            end
         end
         ST_LOOKUP: begin
            next_rvalid = 1'b1;
            next_state  = ST_IDLE;
            if (invalid) begin
               next_rnone  = 1'b1;
               next_rerr   = 1'b0;
               next_rwords = 6'h00;
            end else if (illegal) begin
               next_rnone  = 1'b0;
               next_rerr   = 1'b1;                                  // [RULE2]
               next_rwords = 6'h00;                                 // [RULE2]
               next_supd   = 1'b1;                                  // [RULE2]
            end else begin
               next_rnone  = 1'b0;
               next_rerr   = 1'b0;                                  // [RULE6] [RULE1]
               next_rwords = words;                                 // [RULE6] [RULE1]
               next_supd   = 1'b1;                                  // [RULE6]
            end
         end
         ST_HOST_RD: begin
            next_ack    = 1'b1;
            next_hrdata = host_in_table ? ram.rdata : 16'h0000;
            next_state  = ST_IDLE;
         end
      endcase
   end

   // ==========================================================
   // registers
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         state   <= ST_CLEAR;
         clr_cnt <= 8'h00;
         cmd     <= 16'h0000;
         bcast   <= 1'b0;
         ready   <= 1'b0;
         ack     <= 1'b0;
         hrdata  <= 16'h0000;
         rvalid  <= 1'b0;
         rnone   <= 1'b0;
         rerr    <= 1'b0;
         rwords  <= 6'h00;
         supd    <= 1'b0;
      end else begin
         state   <= next_state;
         clr_cnt <= next_clr_cnt;
         cmd     <= next_cmd;
         bcast   <= next_bcast;
         ready   <= next_ready;
         ack     <= next_ack;
         hrdata  <= next_hrdata;
         rvalid  <= next_rvalid;
         rnone   <= next_rnone;
         rerr    <= next_rerr;
         rwords  <= next_rwords;
         supd    <= next_supd;
      end
   end

   assign READY_O           = ready;
   assign HOST_ACK_O        = ack;
   assign HOST_RDATA_O      = hrdata;
   assign RESP_VALID_O      = rvalid;
   assign RESP_NONE_O       = rnone;
   assign RESP_MSG_ERR_O    = rerr;
   assign RESP_DATA_WORDS_O = rwords;
   assign STATUS_UPDATE_O   = supd;
endmodule

// ===== bench/legality_chk.sv
// checker on the top ports of the legality lookup
// assumes a bind onto rt_command_legality_check
`timescale 1ns/1ns
module legality_chk (
   input  wire logic        CLK_I,
   input  wire logic        RSTN_I,
   input  wire logic        CMD_VALID_I,
   input  wire logic [15:0] CMD_WORD_I,
   input  wire logic        CMD_BCAST_I,
   input  wire logic        READY_O,
   input  wire logic        HOST_ACK_O,
   input  wire logic        RESP_VALID_O,
   input  wire logic        RESP_NONE_O,
   input  wire logic        RESP_MSG_ERR_O,
   input  wire logic [5:0]  RESP_DATA_WORDS_O,
   input  wire logic        STATUS_UPDATE_O
);
   // ==========================================================
   // properties
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RSTN_I);

   resp_latency_a: assert property (
      RESP_VALID_O |-> $past(CMD_VALID_I, 2)) else $error("stray answer");
   none_quiet_a: assert property (
      RESP_VALID_O && RESP_NONE_O |-> !STATUS_UPDATE_O)
      else $error("invalid command updated status");
   err_no_data_a: assert property (
      RESP_VALID_O && RESP_MSG_ERR_O && !RESP_NONE_O
      |-> RESP_DATA_WORDS_O == 6'h00 && STATUS_UPDATE_O)
      else $error("error status with data");
   update_pair_a: assert property (
      STATUS_UPDATE_O |-> RESP_VALID_O && !RESP_NONE_O)
      else $error("status update without answer");
   ready_hold_a: assert property (
      READY_O |=> READY_O) else $error("ready dropped");
   early_ack_a: assert property (
      !READY_O |-> !HOST_ACK_O) else $error("host ack before ready");
   bcast_tx_a: assert property (
      RESP_VALID_O && $past(CMD_BCAST_I && CMD_WORD_I[10], 2)
      && $past(CMD_WORD_I[9:5], 2) inside {[5'h01:5'h1e]}
      |-> RESP_NONE_O) else $error("broadcast transmit answered");
   legal_words_a: assert property (
      RESP_VALID_O && !RESP_NONE_O && !RESP_MSG_ERR_O
      && $past(CMD_WORD_I[9:5], 2) inside {[5'h01:5'h1e]}
      |-> RESP_DATA_WORDS_O == {$past(CMD_WORD_I[4:0], 2) == 5'h00,
                                $past(CMD_WORD_I[4:0], 2)})
      else $error("wrong data word count");

   cover property (RESP_VALID_O && RESP_MSG_ERR_O);
   cover property (RESP_VALID_O && RESP_NONE_O);
   cover property (READY_O && HOST_ACK_O);
endmodule

// ===== bench/bc_model.sv
// bus controller stand-in issuing command words
// assumes the clock of the lookup block
`timescale 1ns/1ns
module bc_model (
   input  wire logic        clk_i,
   output logic             valid_o,
   output logic [15:0]      word_o,
   output logic             bcast_o
);
   // ==========================================================
   // command issue; idle lines carry the inverted last value
   initial begin
      valid_o = 1'b0;
      word_o  = 16'h0000;
      bcast_o = 1'b0;
   end

   task automatic send(input logic [15:0] w, input logic b);
      repeat (2) @(posedge clk_i);
      valid_o <= 1'b1;
      word_o  <= w;
      bcast_o <= b;
      @(posedge clk_i);
      valid_o <= 1'b0;
      word_o  <= ~w;
      bcast_o <= ~b;
   endtask
endmodule

// ===== bench/rt_command_legality_check_bench.sv
// self-checking bench for the legality lookup
// assumes bc_model on the command port, host port driven here
`timescale 1ns/1ns
module rt_command_legality_check_bench;
   // ==========================================================
   // clock, dut, partner, checks
   logic        clk, rst_n, exec, umc, req, we, ready, ack;
   logic        rv, rn, re, ru, cv, cb;
   logic [15:0] addr, wdata, rdata, cw;
   logic [5:0]  rw;
   int          bad_count, checked, cycles;

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   rt_command_legality_check u_dut (.CLK_I(clk), .RSTN_I(rst_n),
      .TERMINAL_EXEC_START_I(exec), .UNDEFINED_MODECODE_INVALID_I(umc),
      .CMD_VALID_I(cv), .CMD_WORD_I(cw), .CMD_BCAST_I(cb),
      .HOST_REQ_I(req), .HOST_WE_I(we), .HOST_ADDR_I(addr),
      .HOST_WDATA_I(wdata), .READY_O(ready), .HOST_ACK_O(ack),
      .HOST_RDATA_O(rdata), .RESP_VALID_O(rv), .RESP_NONE_O(rn),
      .RESP_MSG_ERR_O(re), .RESP_DATA_WORDS_O(rw), .STATUS_UPDATE_O(ru));
   bc_model u_bc (.clk_i(clk), .valid_o(cv), .word_o(cw), .bcast_o(cb));

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count = bad_count + 1;
         finish_test();
      end
   end

   task automatic finish_test;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   function automatic logic [15:0] rs(input logic [2:0] f,
                                      input logic [5:0] w);
      return {7'h00, f[2], f[1], w, f[0]};
   endfunction

   task automatic wr(input logic [15:0] a, d);
      repeat (2) @(posedge clk);
      req <= 1'b1; we <= 1'b1; addr <= a; wdata <= d;
      @(posedge clk);
      req <= 1'b0; we <= 1'b0; addr <= ~a; wdata <= ~d;
      @(negedge clk);
      chk({15'h0000, ack}, 16'h0001);
   endtask

   task automatic rd(input logic [15:0] a, e);
      repeat (2) @(posedge clk);
      req <= 1'b1; addr <= a;
      repeat (2) @(posedge clk);
      req <= 1'b0; addr <= ~a;
      @(negedge clk);
      chk({15'h0000, ack}, 16'h0001);
      chk(rdata, e);
   endtask

   task automatic cmd(input logic [1:0] bt, input logic [4:0] sa, wc,
                      input logic [15:0] e);
      logic [15:0] g;
      int n;
      u_bc.send({5'h05, bt[0], sa, wc}, bt[1]);
      for (n = 0; n < 4 && rv !== 1'b1; n++) @(negedge clk);
      g = (rv === 1'b1) ? {7'h00, rn, re, rw, ru} : 16'hffff;
      if (e == 16'h0100) g = g & 16'h0101;
      chk(g, e);
   endtask

   task automatic t_boot;
      int n;
      rst_n <= 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk({15'h0000, ready}, 16'h0000);
      for (n = 0; n < 400 && ready !== 1'b1; n++) @(negedge clk);
      chk({15'h0000, ready}, 16'h0001);
      rd(16'h02c2, 16'h0000);
      rd(16'h02c3, 16'h0000);
      rd(16'h02ff, 16'h0000);
   endtask

   task automatic t_default;
      @(posedge clk) exec <= 1'b1;
      cmd(2'b00, 5'd3, 5'd0, rs(3'b001, 6'd32));
      cmd(2'b01, 5'd30, 5'd17, rs(3'b001, 6'd17));
      cmd(2'b01, 5'd0, 5'd17, rs(3'b001, 6'd1));
      @(posedge clk) exec <= 1'b0;
      cmd(2'b00, 5'd3, 5'd2, 16'hffff);
      @(posedge clk) exec <= 1'b1;
   endtask

   task automatic t_counts;
      int wc;
      wr(16'h02c2, 16'hff0f);
      wr(16'h02c3, 16'hffff);
      rd(16'h02c2, 16'hff0f);
      for (wc = 0; wc < 32; wc++)
         cmd(2'b01, 5'd1, wc[4:0], (wc >= 4 && wc <= 7) ?
             rs(3'b001, wc[5:0]) : rs(3'b011, 6'd0));
   endtask

   task automatic t_paths;
      wr(16'h0282, 16'h0020);
      cmd(2'b00, 5'd1, 5'd5, rs(3'b011, 6'd0));
      cmd(2'b10, 5'd1, 5'd5, rs(3'b001, 6'd5));
      cmd(2'b00, 5'd1, 5'd21, rs(3'b001, 6'd21));
      cmd(2'b01, 5'd1, 5'd5, rs(3'b001, 6'd5));
      cmd(2'b11, 5'd1, 5'd3, rs(3'b100, 6'd0));
      wr(16'h0102, 16'hffff);
      rd(16'h0202, 16'h0000);
      rd(16'h0102, 16'h0000);
   endtask

   task automatic t_modes;
      wr(16'h02c0, 16'h0004);
      wr(16'h02fe, 16'h0004);
      wr(16'h02ff, 16'h0002);
      cmd(2'b01, 5'd0, 5'd2, rs(3'b011, 6'd0));
      cmd(2'b01, 5'd31, 5'd2, rs(3'b011, 6'd0));
      cmd(2'b01, 5'd31, 5'd3, rs(3'b001, 6'd0));
      cmd(2'b01, 5'd31, 5'd17, rs(3'b011, 6'd0));
      cmd(2'b01, 5'd31, 5'd16, rs(3'b001, 6'd1));
      @(posedge clk) umc <= 1'b1;
      cmd(2'b00, 5'd0, 5'd0, rs(3'b100, 6'd0));
      cmd(2'b01, 5'd0, 5'd21, rs(3'b100, 6'd0));
      @(posedge clk) umc <= 1'b0;
      cmd(2'b00, 5'd0, 5'd0, rs(3'b001, 6'd0));
   endtask

   initial begin
      rst_n = 1'b0; exec = 1'b0; umc = 1'b0; req = 1'b0; we = 1'b0;
      addr = 16'h0000; wdata = 16'h0000;
      bad_count = 0; checked = 0; cycles = 0;
      t_boot();
      t_default();
      t_counts();
      t_paths();
      t_modes();
      t_boot();
      finish_test();
   end
endmodule

bind rt_command_legality_check legality_chk u_chk (.CLK_I(CLK_I),
   .RSTN_I(RSTN_I), .CMD_VALID_I(CMD_VALID_I), .CMD_WORD_I(CMD_WORD_I),
   .CMD_BCAST_I(CMD_BCAST_I), .READY_O(READY_O), .HOST_ACK_O(HOST_ACK_O),
   .RESP_VALID_O(RESP_VALID_O), .RESP_NONE_O(RESP_NONE_O),
   .RESP_MSG_ERR_O(RESP_MSG_ERR_O), .RESP_DATA_WORDS_O(RESP_DATA_WORDS_O),
   .STATUS_UPDATE_O(STATUS_UPDATE_O));
